/* design/dbgmg_pkg.sv */
// package: modes, command classes and status codes of the debug command gate
package dbgmg_pkg;
    // operating modes, one-hot
    typedef enum logic [2:0] {
        DBGMG_RUN  = 3'h1,
        DBGMG_HALT = 3'h2,
        DBGMG_WAIT = 3'h4
    } dbgmg_mode_e;

    // debug command classes seen by the gate
    localparam logic [2:0] CMD_MEM = 3'h0;
    localparam logic [2:0] CMD_MEM_STAT = 3'h1;
    localparam logic [2:0] CMD_CTRL_REG = 3'h2;
    localparam logic [2:0] CMD_ENTER_HALT = 3'h3;
    localparam logic [2:0] CMD_CPU_REG = 3'h4;
    localparam logic [2:0] CMD_STEP = 3'h5;
    localparam logic [2:0] CMD_RESUME = 3'h6;
    localparam logic [2:0] CMD_NONE = 3'h7;

    // status returned with memory-access-with-status commands
    localparam logic [1:0] STAT_OK = 2'h0;
    localparam logic [1:0] STAT_STOP_WAIT = 2'h1;
    localparam logic [1:0] STAT_DISCARD = 2'h2;

    localparam logic [7:0] CCR_RESET = 8'hFF;
    localparam int CCR_IMASK_BIT = 3;
endpackage

/* design/dbgmg_if.sv */
// interface: classified command from decoder to gate
`timescale 1ns/1ps
interface dbgmg_if;
    import dbgmg_pkg::*;
    logic valid;
    logic [2:0] cls;
    modport src (output valid, output cls);
    modport dst (input valid, input cls);
endinterface

/* design/dbgmg_decode.sv */
// module: turns a raw command strobe into a classified command
`timescale 1ns/1ps
module dbgmg_decode (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_class,
    dbgmg_if.src cmd
);
    import dbgmg_pkg::*;
    logic valid;
    logic [2:0] cls;
    logic next_valid;
    logic [2:0] next_cls;

    always_comb begin
        next_valid = cmd_valid && (cmd_class != CMD_NONE);
        next_cls = cmd_valid ? cmd_class : CMD_NONE;
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            valid <= 1'b0;
            cls <= CMD_NONE;
        end else begin
            valid <= next_valid;
            cls <= next_cls;
        end
    end

    assign cmd.valid = valid;
    assign cmd.cls = cls;
endmodule

/* design/dbgmg_gate.sv */
// module: debug command gating per operating mode and wait-state control
`timescale 1ns/1ps
module dbgmg_gate (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_class,
    input wire logic wait_exec,
    input wire logic irq_req,
    input wire logic [7:0] ccr_in,
    input wire logic ccr_load,
    output logic core_clk_en,
    output logic [7:0] condition_code_register,
    output logic stack_start,
    output logic mem_go,
    output logic ctrl_reg_go,
    output logic cpu_reg_go,
    output logic step_go,
    output logic status_valid,
    output logic [1:0] status_code,
    output logic cmd_drop,
    output logic [2:0] mode
);
    import dbgmg_pkg::*;

    dbgmg_if cmd_bus();

    dbgmg_decode u_decode (
        .mclk(mclk),
        .rstn(rstn),
        .cmd_valid(cmd_valid),
        .cmd_class(cmd_class),
        .cmd(cmd_bus)
    );

    dbgmg_mode_e state;
    dbgmg_mode_e next_state;
    logic [7:0] next_ccr;
    logic next_clk_en;
    logic next_stack;
    logic next_mem;
    logic next_ctrl;
    logic next_cpu;
    logic next_step;
    logic next_stat_v;
    logic [1:0] next_stat;
    logic next_drop;
    logic is_nonintr;
    logic is_haltonly;

    // ----------------------------------------
    // command classification
    // ----------------------------------------
    always_comb begin
        is_nonintr = (cmd_bus.cls == CMD_MEM) || (cmd_bus.cls == CMD_MEM_STAT)
                     || (cmd_bus.cls == CMD_CTRL_REG) || (cmd_bus.cls == CMD_ENTER_HALT);
        is_haltonly = (cmd_bus.cls == CMD_CPU_REG) || (cmd_bus.cls == CMD_STEP)
                      || (cmd_bus.cls == CMD_RESUME);
    end

    // ----------------------------------------
    // mode control and command gating
    // ----------------------------------------
    always_comb begin
        next_state = state;
        next_ccr = condition_code_register;
        next_clk_en = core_clk_en;
        next_stack = 1'b0;
        next_mem = 1'b0;
        next_ctrl = 1'b0;
        next_cpu = 1'b0;
        next_step = 1'b0;
        next_stat_v = 1'b0;
        next_stat = STAT_OK;
        next_drop = 1'b0;
        if (ccr_load && state != DBGMG_WAIT) begin
            next_ccr = ccr_in;
        end
        case (state)
            DBGMG_RUN, DBGMG_HALT: begin
                if (cmd_bus.valid && is_nonintr) begin
                    next_mem = (cmd_bus.cls == CMD_MEM) || (cmd_bus.cls == CMD_MEM_STAT);
                    next_ctrl = (cmd_bus.cls == CMD_CTRL_REG);
                    next_stat_v = (cmd_bus.cls == CMD_MEM_STAT);
                    if (cmd_bus.cls == CMD_ENTER_HALT) begin
                        next_state = DBGMG_HALT;
                    end
                end else if (cmd_bus.valid && is_haltonly && state == DBGMG_HALT) begin
                    next_cpu = (cmd_bus.cls == CMD_CPU_REG);
                    next_step = (cmd_bus.cls == CMD_STEP);
                    if (cmd_bus.cls == CMD_RESUME) begin
                        next_state = DBGMG_RUN;
                    end
                end else if (cmd_bus.valid) begin
                    next_drop = 1'b1;
                end else if (wait_exec && state == DBGMG_RUN) begin
                    next_state = DBGMG_WAIT;
                    next_clk_en = 1'b0;
                    next_ccr[CCR_IMASK_BIT] = 1'b0;
                end
            end
            DBGMG_WAIT: begin
                if (cmd_bus.valid && cmd_bus.cls == CMD_ENTER_HALT) begin
                    next_state = DBGMG_HALT;
                    next_clk_en = 1'b1;
                end else if (cmd_bus.valid && cmd_bus.cls == CMD_MEM_STAT) begin
                    next_stat_v = 1'b1;
                    next_stat = STAT_STOP_WAIT;
                end else if (cmd_bus.valid) begin
                    next_drop = 1'b1;
                end else if (irq_req) begin
                    next_state = DBGMG_RUN;
                    next_clk_en = 1'b1;
                    next_stack = 1'b1;
                end
            end
            default: begin
                next_state = DBGMG_RUN;
                next_clk_en = 1'b1;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state <= DBGMG_RUN;
            condition_code_register <= CCR_RESET;
            core_clk_en <= 1'b1;
            stack_start <= 1'b0;
            mem_go <= 1'b0;
            ctrl_reg_go <= 1'b0;
            cpu_reg_go <= 1'b0;
            step_go <= 1'b0;
            status_valid <= 1'b0;
            status_code <= STAT_OK;
            cmd_drop <= 1'b0;
        end else begin
            state <= next_state;
            condition_code_register <= next_ccr;
            core_clk_en <= next_clk_en;
            stack_start <= next_stack;
            mem_go <= next_mem;
            ctrl_reg_go <= next_ctrl;
            cpu_reg_go <= next_cpu;
            step_go <= next_step;
            status_valid <= next_stat_v;
            status_code <= next_stat;
            cmd_drop <= next_drop;
        end
    end

    assign mode = state;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    // halt-only never outside halt
    a_haltonly_in_halt: assert property (@(posedge mclk) disable iff (!rstn)
        (cpu_reg_go || step_go) |-> $past(state) == DBGMG_HALT) else $error("halt-only command outside halt");
    a_wait_no_mem: assert property (@(posedge mclk) disable iff (!rstn)
        mem_go |-> $past(state) != DBGMG_WAIT) else $error("memory access during wait");
    a_wait_status_err: assert property (@(posedge mclk) disable iff (!rstn)
        (state == DBGMG_WAIT && cmd_bus.valid && cmd_bus.cls == CMD_MEM_STAT)
        |=> status_valid && status_code == STAT_STOP_WAIT) else $error("no error status in wait");
    a_wait_clk_off: assert property (@(posedge mclk) disable iff (!rstn)
        state == DBGMG_WAIT |-> !core_clk_en) else $error("core clock running in wait");
    a_wait_mask_clr: assert property (@(posedge mclk) disable iff (!rstn)
        ($past(state) == DBGMG_RUN && state == DBGMG_WAIT) |-> !condition_code_register[CCR_IMASK_BIT])
        else $error("mask not cleared at wait entry");
    a_irq_wake: assert property (@(posedge mclk) disable iff (!rstn)
        (state == DBGMG_WAIT && !cmd_bus.valid && irq_req) |=> state == DBGMG_RUN && stack_start && core_clk_en)
        else $error("interrupt did not wake");
    a_wait_to_halt: assert property (@(posedge mclk) disable iff (!rstn)
        (state == DBGMG_WAIT && cmd_bus.valid && cmd_bus.cls == CMD_ENTER_HALT) |=> state == DBGMG_HALT && core_clk_en)
        else $error("enter-halt did not wake");
    a_resume_run: assert property (@(posedge mclk) disable iff (!rstn)
        (state == DBGMG_HALT && cmd_bus.valid && cmd_bus.cls == CMD_RESUME) |=> state == DBGMG_RUN)
        else $error("resume did not return to run");
    a_run_mem: assert property (@(posedge mclk) disable iff (!rstn)
        (state == DBGMG_RUN && cmd_bus.valid && cmd_bus.cls == CMD_MEM) |=> mem_go && !cmd_drop)
        else $error("run memory access not served");
    a_halt_mem: assert property (@(posedge mclk) disable iff (!rstn)
        (state == DBGMG_HALT && cmd_bus.valid && cmd_bus.cls == CMD_MEM) |=> mem_go && !cmd_drop)
        else $error("halt memory access not served");
    a_halt_step: assert property (@(posedge mclk) disable iff (!rstn)
        (state == DBGMG_HALT && cmd_bus.valid && cmd_bus.cls == CMD_STEP) |=> step_go && state == DBGMG_HALT)
        else $error("step not served in halt");
    a_halt_cpu_reg: assert property (@(posedge mclk) disable iff (!rstn)
        (state == DBGMG_HALT && cmd_bus.valid && cmd_bus.cls == CMD_CPU_REG) |=> cpu_reg_go)
        else $error("cpu register access not served in halt");
    a_run_drop_haltonly: assert property (@(posedge mclk) disable iff (!rstn)
        (state == DBGMG_RUN && cmd_bus.valid && is_haltonly) |=> cmd_drop && state == DBGMG_RUN)
        else $error("halt-only command not dropped in run");
    a_run_enter_halt: assert property (@(posedge mclk) disable iff (!rstn)
        (state == DBGMG_RUN && cmd_bus.valid && cmd_bus.cls == CMD_ENTER_HALT) |=> state == DBGMG_HALT)
        else $error("enter-halt not taken in run");
    // wait runs nothing but status and enter-halt
    a_wait_only_two: assert property (@(posedge mclk) disable iff (!rstn)
        state == DBGMG_WAIT |=> !ctrl_reg_go && !cpu_reg_go && !step_go)
        else $error("forbidden command ran in wait");
    a_wait_entry: assert property (@(posedge mclk) disable iff (!rstn)
        (state == DBGMG_RUN && !cmd_bus.valid && wait_exec) |=> state == DBGMG_WAIT)
        else $error("wait instruction ignored in run");
    a_drop_no_effect: assert property (@(posedge mclk) disable iff (!rstn)
        cmd_drop |-> state == $past(state) && !mem_go && !step_go && !cpu_reg_go)
        else $error("dropped command had effect");
endmodule

/* testbench/dbgmg_host.sv */
// debug host model: issues classified debug commands to the gate
`timescale 1ns/1ps
module dbgmg_host (
    input wire logic mclk,
    output logic cmd_valid,
    output logic [2:0] cmd_class
);
    import dbgmg_pkg::*;
    initial begin
        cmd_valid = 1'h0;
        cmd_class = CMD_NONE;
    end
    // class parked at none between strobes so a stale class is never mistaken for a command
    task automatic issue(input logic [2:0] cls);
        @(negedge mclk);
        cmd_valid = 1'h1;
        cmd_class = cls;
        @(negedge mclk);
        cmd_valid = 1'h0;
        cmd_class = CMD_NONE;
    endtask
endmodule

/* testbench/testbench.sv */
// testbench: mode gating, wait entry and wake of the debug command gate
`timescale 1ns/1ps
module testbench;
    import dbgmg_pkg::*;
    logic mclk, rstn, cmd_valid, wait_exec, irq_req, ccr_load;
    logic [2:0] cmd_class, mode, cur;
    logic [7:0] ccr_in, condition_code_register;
    logic core_clk_en, stack_start, mem_go, ctrl_reg_go, cpu_reg_go, step_go, status_valid, cmd_drop;
    logic [1:0] status_code;
    int n_mismatch = 0;
    int n_checks = 0;
    dbgmg_host host (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_class(cmd_class));
    dbgmg_gate DUT (.mclk(mclk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_class(cmd_class),
        .wait_exec(wait_exec), .irq_req(irq_req), .ccr_in(ccr_in), .ccr_load(ccr_load),
        .core_clk_en(core_clk_en), .condition_code_register(condition_code_register),
        .stack_start(stack_start), .mem_go(mem_go), .ctrl_reg_go(ctrl_reg_go), .cpu_reg_go(cpu_reg_go),
        .step_go(step_go), .status_valid(status_valid), .status_code(status_code), .cmd_drop(cmd_drop),
        .mode(mode));
    initial begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end
    // ----------------------------------------
    // expectations and checking
    // ----------------------------------------
    // pulse order: mem, ctrl reg, cpu reg, step, status, drop
    function automatic logic [5:0] exp_go(input logic [2:0] c, input logic [2:0] m);
        if (m == DBGMG_WAIT)
            return (c == CMD_MEM_STAT) ? 6'h02 : (c == CMD_ENTER_HALT) ? 6'h00 : 6'h01;
        if (m == DBGMG_RUN && c >= CMD_CPU_REG)
            return 6'h01;
        case (c)
            CMD_MEM: return 6'h20;
            CMD_MEM_STAT: return 6'h22;
            CMD_CTRL_REG: return 6'h10;
            CMD_CPU_REG: return 6'h08;
            CMD_STEP: return 6'h04;
            default: return 6'h00;
        endcase
    endfunction
    function automatic logic [2:0] exp_mode(input logic [2:0] c, input logic [2:0] m);
        if (c == CMD_ENTER_HALT) return DBGMG_HALT;
        if (c == CMD_RESUME && m == DBGMG_HALT) return DBGMG_RUN;
        return m;
    endfunction
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic cmd_chk(input logic [2:0] cls);
        logic [5:0] e;
        logic [2:0] m;
        m = cur;
        e = exp_go(cls, m);
        cur = exp_mode(cls, m);
        host.issue(cls);
        // pulses stand only between the second and third edge after the strobe
        @(negedge mclk);
        check("pulses", {2'h0, mem_go, ctrl_reg_go, cpu_reg_go, step_go, status_valid, cmd_drop}, {2'h0, e});
        if (e[1]) check("status", {6'h0, status_code}, {6'h0, (m == DBGMG_WAIT) ? STAT_STOP_WAIT : STAT_OK});
        check("mode", {5'h0, mode}, {5'h0, cur});
        check("clk_en", {7'h0, core_clk_en}, {7'h0, cur != DBGMG_WAIT});
    endtask
    task automatic pulse_wait();
        @(negedge mclk);
        wait_exec = 1'h1;
        @(negedge mclk);
        wait_exec = 1'h0;
        cur = DBGMG_WAIT;
        check("mode", {5'h0, mode}, {5'h0, cur});
        check("clk_en", {7'h0, core_clk_en}, 8'h00);
        check("ccr", condition_code_register, 8'hF6);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        check("mode", {5'h0, mode}, {5'h0, DBGMG_RUN});
        check("ccr", condition_code_register, CCR_RESET);
    endtask
    // reset in mid-run from halt, then run mode must serve again
    task automatic t_run_halt();
        @(negedge mclk);
        rstn = 1'h0;
        repeat (4) @(negedge mclk);
        rstn = 1'h1;
        cur = DBGMG_RUN;
        t_reset();
        check("clk_en", {7'h0, core_clk_en}, 8'h01);
        cmd_chk(CMD_MEM);
    endtask
    task automatic t_modes();
        for (int i = 0; i < 7; i++) if (i != 3) cmd_chk(3'(i));
        cmd_chk(CMD_ENTER_HALT);
        for (int i = 0; i < 7; i++) cmd_chk(3'(i));
    endtask
    task automatic t_wait_irq();
        @(negedge mclk);
        ccr_in = 8'hFE;
        ccr_load = 1'h1;
        @(negedge mclk);
        ccr_load = 1'h0;
        check("ccr", condition_code_register, 8'hFE);
        pulse_wait();
        for (int i = 0; i < 7; i++) if (i != 3) cmd_chk(3'(i));
        ccr_in = 8'h00;
        ccr_load = 1'h1;
        @(negedge mclk);
        ccr_load = 1'h0;
        irq_req = 1'h1;
        @(negedge mclk);
        irq_req = 1'h0;
        cur = DBGMG_RUN;
        check("wake", {5'h0, stack_start, core_clk_en, mode == DBGMG_RUN}, 8'h07);
        check("ccr", condition_code_register, 8'hF6);
    endtask
    task automatic t_wait_halt();
        pulse_wait();
        cmd_chk(CMD_ENTER_HALT);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #20000;
        n_mismatch++;
        end_sim();
    end
    initial begin
        rstn = 1'h0;
        wait_exec = 1'h0;
        irq_req = 1'h0;
        ccr_load = 1'h0;
        ccr_in = 8'h00;
        cur = DBGMG_RUN;
        repeat (4) @(negedge mclk);
        rstn = 1'h1;
        t_reset();
        t_modes();
        t_wait_irq();
        t_wait_halt();
        t_run_halt();
        end_sim();
    end
endmodule
